/* pkg/tmr_vote_pkg.sv */
// Shared constants and types for the redundant input voter.
// Assumes a 250 MHz APB clock and three 16-channel input boards.
package tmr_vote_pkg;

  // Board and channel counts
  localparam int NCH  = 16;
  localparam int NBRD = 3;

  // Clock and scan timing
  localparam int CLK_PS    = 4000;                // Clock period in ps
  localparam int SCAN_NS   = 1000;                // Default scan period in ns
  localparam int SCAN_CYC  = (SCAN_NS * 1000) / CLK_PS;

  // Register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;         // Enable and mode
  localparam logic [7:0] A_SCAN  = 8'h04;         // Scan period in cycles
  localparam logic [7:0] A_VOTED = 8'h08;         // Voted channel word
  localparam logic [7:0] A_FAULT = 8'h0c;         // Board health bits
  localparam logic [7:0] A_DISC  = 8'h10;         // Packed discrepancy word
  localparam logic [7:0] A_ISTAT = 8'h14;         // Sticky events, write one clears
  localparam logic [7:0] A_IMASK = 8'h18;         // Event enables
  localparam logic [7:0] A_HLOC  = 8'h1c;         // Host chassis and slot

  // Control fields and reset values
  localparam int          CTRL_EN      = 0;       // Scanning enabled
  localparam int          CTRL_SIMPLEX = 1;       // Single board pass-through
  localparam logic [1:0]  CTRL_RST     = 2'h1;
  localparam logic [15:0] SCAN_RST     = 16'(SCAN_CYC);
  localparam logic [15:0] SCAN_MIN     = 16'h0002;

  // Event bits
  localparam int         EV_DISC  = 0;            // Some channel disagrees
  localparam int         EV_FAULT = 1;            // A board turned faulty
  localparam int         EV_SCAN  = 2;            // A scan completed
  localparam int         EV_W     = 3;
  localparam logic [2:0] IMASK_RST = 3'h0;

  // Host location fields and limits
  localparam int         HLOC_CH_LSB  = 0;
  localparam int         HLOC_SL_LSB  = 8;
  localparam int         HLOC_BAD_BIT = 16;
  localparam logic [3:0] HCH_MAX      = 4'ha;
  localparam logic [3:0] HSL_MAX_C1   = 4'h8;
  localparam logic [3:0] HSL_MAX_EXP  = 4'hc;
  localparam logic [3:0] HLOC_RST     = 4'h1;

  // One board as seen on its pins
  typedef struct packed {
    logic             present;                    // Board fitted
    logic             fault;                      // Board reports a fault
    logic [NCH-1:0]   data;                       // Channel 1 in bit 0
  } board_in_t;

  // One scan's worth of results
  typedef struct packed {
    logic [NCH-1:0]   voted;                      // Voted channel values
    logic [NBRD-1:0]  fault;                      // Board 1 in bit 0
    logic [NCH-1:0]   disc;                       // Channel 1 in bit 0
  } scan_res_t;

endpackage : tmr_vote_pkg

/* verilog/vote_core.sv */
// Combinational per-channel vote and discrepancy for three boards.
// Assumes the board samples are already in the pclk domain.
`timescale 1ns/100ps
module vote_core
  import tmr_vote_pkg::*;
(
  // Board samples
  input  wire tmr_vote_pkg::board_in_t brd [tmr_vote_pkg::NBRD],
  input  wire logic                    simplex,
  // Results
  output logic [tmr_vote_pkg::NCH-1:0] voted,
  output logic [tmr_vote_pkg::NCH-1:0] disc
);
  import tmr_vote_pkg::*;

  // Two of three majority
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  logic [NBRD-1:0] pres;                          // Fitted boards

  always_comb begin
    for (int b = 0; b < NBRD; b++) begin
      pres[b] = brd[b].present;
    end
  end

  // One voter per channel
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      logic [NBRD-1:0] ones;                      // Present boards reading high
      assign ones = pres & {brd[2].data[c], brd[1].data[c], brd[0].data[c]};
      always_comb begin
        if (simplex) begin
          voted[c] = brd[0].data[c];
          disc[c]  = 1'b0;
        end else if (&pres) begin
          voted[c] = maj3(ones);
          disc[c]  = (ones != 3'h0) && (ones != 3'h7);
        end else begin
          // Degraded: remaining boards must agree high
          voted[c] = (pres != 3'h0) && (ones == pres);
          disc[c]  = (ones != 3'h0) && (ones != pres);
        end
      end
    end
  endgenerate

endmodule : vote_core

/* verilog/tmr_input_voter.sv */
// Top of the redundant input voter: pin sync, scan timing, result
// registers, APB register file and interrupt.
// Assumes board pins are asynchronous to pclk.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module tmr_input_voter
  import tmr_vote_pkg::*;
(
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic [7:0]                paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Board pins
  input  wire tmr_vote_pkg::board_in_t   board_pin [tmr_vote_pkg::NBRD],
  // Results
  output tmr_vote_pkg::scan_res_t        result,
  output logic                           disc_flag [tmr_vote_pkg::NCH],
  output logic                           scan_strobe,
  // Interrupt
  output logic                           irq
);
  import tmr_vote_pkg::*;

  // Address decode, used by the error path
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == A_CTRL) || (a == A_SCAN) || (a == A_VOTED) ||
              (a == A_FAULT) || (a == A_DISC) || (a == A_ISTAT) ||
              (a == A_IMASK) || (a == A_HLOC);
  endfunction : addr_ok

  // Register state
  board_in_t       sync1_r [NBRD];                // First sync stage
  board_in_t       sync2_r [NBRD];                // Second sync stage
  logic [1:0]      ctrl_r;                        // Enable and simplex
  logic [15:0]     scan_r;                        // Scan period
  logic [15:0]     cnt_r;                         // Scan divider
  logic            tick_r;                        // Scan enable pulse
  scan_res_t       res_r;                         // Result registers
  logic            dflag_r [NCH];                 // Unpacked flags
  logic            strobe_r;                      // Result updated
  logic [EV_W-1:0] istat_r;                       // Sticky events
  logic [EV_W-1:0] imask_r;                       // Event enables
  logic            irq_r;                         // Interrupt level
  logic [3:0]      hch_r;                         // Host chassis number
  logic [3:0]      hsl_r;                         // Host slot number
  logic [31:0]     prdata_r;
  logic            pready_r;
  logic            pslverr_r;

  // Combinational terms
  scan_res_t       res_nxt;                       // Result of this scan
  logic [NCH-1:0]  voted_w;
  logic [NCH-1:0]  disc_w;
  logic [EV_W-1:0] ev_w;                          // Events this cycle
  logic [EV_W-1:0] istat_nxt;
  logic            hloc_bad;                      // Host location out of range
  logic            acc;                           // First access cycle
  logic            wr_en;                         // Write takes effect
  logic            simplex;

  assign simplex = ctrl_r[CTRL_SIMPLEX];
  assign acc     = psel & penable & ~pready_r;
  assign wr_en   = psel & penable & pready_r & pwrite;

  // Two-stage synchroniser on all board pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < NBRD; b++) begin
        sync1_r[b] <= '0;
        sync2_r[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NBRD; b++) begin
        sync1_r[b] <= board_pin[b];
        sync2_r[b] <= sync1_r[b];
      end
    end
  end

  // Per-channel voter on synchronised samples
  vote_core u_vote (
    .brd     (sync2_r),
    .simplex (simplex),
    .voted   (voted_w),
    .disc    (disc_w)
  );

  // Host location range check
  always_comb begin
    hloc_bad = (hch_r == 4'h0) || (hch_r > HCH_MAX) || (hsl_r == 4'h0) ||
               (hsl_r > ((hch_r == 4'h1) ? HSL_MAX_C1 : HSL_MAX_EXP));
  end

  // Scan divider: one tick each period while enabled and located
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (!ctrl_r[CTRL_EN] || hloc_bad) begin
      // Idle: clear divider
      cnt_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (cnt_r >= scan_r - 16'h0001) begin
      // Period reached
      cnt_r  <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Assemble the next result from one set of samples
  always_comb begin
    res_nxt.voted = voted_w;
    res_nxt.disc  = disc_w;
    if (simplex) begin
      // Single board health only
      res_nxt.fault = {2'h0, sync2_r[0].fault | ~sync2_r[0].present};
    end else begin
      for (int b = 0; b < NBRD; b++) begin
        res_nxt.fault[b] = sync2_r[b].fault | ~sync2_r[b].present;
      end
    end
  end

  // Result registers load together on the scan tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r    <= '0;
      strobe_r <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        dflag_r[c] <= 1'b0;
      end
    end else begin
      strobe_r <= tick_r;
      if (tick_r) begin
        res_r <= res_nxt;
        for (int c = 0; c < NCH; c++) begin
          dflag_r[c] <= res_nxt.disc[c];
        end
      end
    end
  end

  // Events raised by a scan
  always_comb begin
    ev_w           = '0;
    ev_w[EV_SCAN]  = tick_r;
    ev_w[EV_DISC]  = tick_r & (|res_nxt.disc);
    ev_w[EV_FAULT] = tick_r & (|(res_nxt.fault & ~res_r.fault));
    // Set wins over a clear in the same cycle
    istat_nxt = istat_r;
    if (wr_en && paddr == A_ISTAT) begin
      istat_nxt = istat_r & ~pwdata[EV_W-1:0];
    end
    istat_nxt = istat_nxt | ev_w;
  end

  // Sticky status and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= '0;
      irq_r   <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_r   <= |(istat_nxt & imask_r);
    end
  end

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= CTRL_RST;
      scan_r  <= SCAN_RST;
      imask_r <= IMASK_RST;
      hch_r   <= HLOC_RST;
      hsl_r   <= HLOC_RST;
    end else if (wr_en) begin
      unique case (paddr)
        A_CTRL:  ctrl_r  <= pwdata[1:0];
        // Keep at least two cycles per scan
        A_SCAN:  scan_r  <= (pwdata[15:0] < SCAN_MIN) ? SCAN_MIN : pwdata[15:0];
        A_IMASK: imask_r <= pwdata[EV_W-1:0];
        A_HLOC: begin
          hch_r <= pwdata[HLOC_CH_LSB +: 4];
          hsl_r <= pwdata[HLOC_SL_LSB +: 4];
        end
        // Read-only or unmapped: ignored
        default: ;
      endcase
    end
  end

  // APB answer: one wait state, data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc & ~addr_ok(paddr);
      if (acc && !pwrite) begin
        unique case (paddr)
          A_CTRL:  prdata_r <= {30'h0, ctrl_r};
          A_SCAN:  prdata_r <= {16'h0, scan_r};
          A_VOTED: prdata_r <= {16'h0, res_r.voted};
          A_FAULT: prdata_r <= {29'h0, res_r.fault};
          A_DISC:  prdata_r <= {16'h0, res_r.disc};
          A_ISTAT: prdata_r <= {29'h0, istat_r};
          A_IMASK: prdata_r <= {29'h0, imask_r};
          A_HLOC:  prdata_r <= {15'h0, hloc_bad, 4'h0, hsl_r, 4'h0, hch_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Outputs straight from flops
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign result      = res_r;
  assign disc_flag   = dflag_r;
  assign scan_strobe = strobe_r;
  assign irq         = irq_r;

  // Checking helpers on synchronised samples
  logic [NCH-1:0] d0, d1, d2;
  logic [2:0]     pres_w;
  logic [2:0]     flt_w;
  assign d0     = sync2_r[0].data;
  assign d1     = sync2_r[1].data;
  assign d2     = sync2_r[2].data;
  assign pres_w = {sync2_r[2].present, sync2_r[1].present, sync2_r[0].present};
  assign flt_w  = {sync2_r[2].fault, sync2_r[1].fault, sync2_r[0].fault};

  property p_vote_maj;
    @(posedge pclk) disable iff (!presetn)
    tick_r && !simplex && pres_w == 3'h7 |=>
      result.voted == $past((d0 & d1) | (d0 & d2) | (d1 & d2));
  endproperty
  a_vote_maj: assert property (p_vote_maj) else $error("majority vote wrong");

  property p_vote_level;
    @(posedge pclk) disable iff (!presetn)
    tick_r && !simplex && pres_w == 3'h7 && d0 == d1 && d1 == d2 |=>
      result.voted == $past(d0);
  endproperty
  a_vote_level: assert property (p_vote_level) else $error("agreed level lost");

  property p_fault3;
    @(posedge pclk) disable iff (!presetn)
    tick_r && !simplex |=> result.fault == $past(flt_w | ~pres_w);
  endproperty
  a_fault3: assert property (p_fault3) else $error("board fault bits wrong");

  property p_disc;
    @(posedge pclk) disable iff (!presetn)
    tick_r && !simplex && pres_w == 3'h7 |=>
      result.disc == $past((d0 ^ d1) | (d1 ^ d2));
  endproperty
  a_disc: assert property (p_disc) else $error("discrepancy word wrong");

  property p_disc_clear;
    @(posedge pclk) disable iff (!presetn)
    tick_r && !simplex && pres_w == 3'h7 && result.disc != 16'h0000 &&
      d0 == d1 && d1 == d2 |=>
      result.disc == 16'h0000 && disc_flag[0] == 1'b0 && disc_flag[15] == 1'b0;
  endproperty
  a_disc_clear: assert property (p_disc_clear) else $error("discrepancy held");

  property p_unpacked;
    @(posedge pclk) disable iff (!presetn)
    strobe_r |-> disc_flag[0] == result.disc[0] && disc_flag[15] == result.disc[15];
  endproperty
  a_unpacked: assert property (p_unpacked) else $error("flag order wrong");

  property p_simplex;
    @(posedge pclk) disable iff (!presetn)
    tick_r && simplex |=> result.voted == $past(d0) && result.disc == 16'h0000;
  endproperty
  a_simplex: assert property (p_simplex) else $error("simplex pass wrong");

  property p_simplex_flt;
    @(posedge pclk) disable iff (!presetn)
    tick_r && simplex |=>
      result.fault == {2'h0, $past(sync2_r[0].fault | ~sync2_r[0].present)};
  endproperty
  a_simplex_flt: assert property (p_simplex_flt) else $error("simplex fault wrong");

  property p_degraded;
    @(posedge pclk) disable iff (!presetn)
    tick_r && !simplex && pres_w == 3'h3 |=> result.voted == $past(d0 & d1);
  endproperty
  a_degraded: assert property (p_degraded) else $error("two-board vote wrong");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !tick_r |=> $stable(result) ##0 !scan_strobe;
  endproperty
  a_hold: assert property (p_hold) else $error("result moved off scan");

  property p_hloc;
    @(posedge pclk) disable iff (!presetn)
    hloc_bad |=> !tick_r [*2];
  endproperty
  a_hloc: assert property (p_hloc) else $error("scan with bad location");

  // Main scenarios
  c_simplex:  cover property (@(posedge pclk) disable iff (!presetn) tick_r && simplex);
  c_disc:     cover property (@(posedge pclk) disable iff (!presetn) strobe_r && |result.disc);
  c_degraded: cover property (@(posedge pclk) disable iff (!presetn) tick_r && pres_w == 3'h3);
  c_irq:      cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule : tmr_input_voter

/* bench/board_model.sv */
// Behavioural model of one redundant input board on the I/O bus.
// Assumes the bench commands its state; pins change just after pclk rises.
`timescale 1ns/100ps
module board_model
  import tmr_vote_pkg::*;
#(
  parameter int BRD_CHASSIS = 1,                 // Board chassis number
  parameter int BRD_SLOT    = 1                  // Board slot number
)
(
  // Clock
  input  wire logic                       pclk,
  // Commanded state
  input  wire logic                       fit,
  input  wire logic                       flt,
  input  wire logic [tmr_vote_pkg::NCH-1:0] chan,
  // Board pins
  output tmr_vote_pkg::board_in_t         pin
);
  // Location must sit in the legal ranges
  localparam bit LOC_OK = (BRD_CHASSIS >= 1) && (BRD_CHASSIS <= 16) &&
                          (BRD_SLOT >= 1) && (BRD_SLOT <= 10);

  // Quiet pins at time zero, and an early word on a bad location
  initial begin
    pin = '0;
    if (!LOC_OK) begin
      $display("ERROR board location out of range");
    end
  end

  // Drive pins; a pulled board leaves its lines wandering
  always @(posedge pclk) begin
    pin.present <= fit;
    if (fit) begin
      pin.fault <= flt;
      pin.data  <= chan;
    end else begin
      // Absent board: lines change every cycle
      pin.fault <= ~pin.fault;
      pin.data  <= ~pin.data;
    end
  end
endmodule : board_model

/* bench/testbench.sv */
// Self-checking bench for the redundant input voter.
// Assumes three board models on the pins and an APB master in tasks.
`timescale 1ns/100ps
module testbench;
  import tmr_vote_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;   // Bus controls
  logic [7:0]  paddr;                                  // Byte address
  logic [31:0] pwdata, prdata, rdat;                   // Data words
  logic        pready, pslverr, rerr, scan_strobe, irq; // Answers
  board_in_t   pins [NBRD];                            // Board pins
  scan_res_t   result;                                 // Scan results
  logic        disc_flag [NCH];                        // Unpacked flags
  logic [15:0] b_dat [NBRD];                           // Board data
  logic        b_fit [NBRD], b_flt [NBRD];             // Board state
  int          err_count, num_checks;                  // Tallies

  // Device under test
  tmr_input_voter u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .board_pin(pins),
    .result(result), .disc_flag(disc_flag), .scan_strobe(scan_strobe), .irq(irq));

  // Three boards, each at its own slot
  for (genvar g = 0; g < NBRD; g++) begin : g_brd
    board_model #(.BRD_CHASSIS(1), .BRD_SLOT(g + 1)) u_brd (.pclk(pclk),
      .fit(b_fit[g]), .flt(b_flt[g]), .chan(b_dat[g]), .pin(pins[g]));
  end

  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Compare and tally
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Print counts and verdict
  task conclude;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // One APB transfer; waits for pready under a bound
  task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write and checked read
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rdat, e);
    chk(32'(rerr), 32'h0);
  endtask : rdchk

  // Count scans; results must hold between strobes
  task wait_scan(input int k);
    int n;
    scan_res_t prev;
    n = 0;
    prev = result;
    while (k > 0 && n < 2000) begin
      @(posedge pclk);
      #1;
      n++;
      if (scan_strobe === 1'b1) k--;
      else if (result !== prev) chk(32'h0, 32'h1);
      prev = result;
    end
    if (n >= 2000) chk(32'h0, 32'h2);
  endtask : wait_scan

  // Command the three boards
  task set_brd(input logic [15:0] d0, d1, d2, input logic [2:0] fl, ft);
    @(posedge pclk);
    b_dat[0] <= d0;
    b_dat[1] <= d1;
    b_dat[2] <= d2;
    for (int i = 0; i < NBRD; i++) begin
      b_flt[i] <= fl[i];
      b_fit[i] <= ft[i];
    end
  endtask : set_brd

  // Settle, then judge the result port, the flags and the voted and discrepancy reads
  task chk_res(input logic [15:0] v, input logic [2:0] f, input logic [15:0] d);
    wait_scan(3);
    chk(32'(result.voted), 32'(v));
    chk(32'(result.fault), 32'(f));
    chk(32'(result.disc), 32'(d));
    for (int i = 0; i < NCH; i++) chk(32'(disc_flag[i]), 32'(d[i]));
    rdchk(A_VOTED, 32'(v));
    rdchk(A_DISC, 32'(d));
  endtask : chk_res

  // Reset values, unmapped and read-only places, scan floor
  task t_reset;
    @(posedge pclk);
    #1;
    chk(32'(result.voted | result.disc), 32'h0);
    chk(32'(irq), 32'h0);
    rdchk(A_CTRL, 32'(CTRL_RST));
    rdchk(A_SCAN, 32'(SCAN_RST));
    rdchk(A_IMASK, 32'(IMASK_RST));
    rdchk(A_HLOC, {20'h0, HLOC_RST, 4'h0, HLOC_RST});
    wr(A_VOTED, 32'hffff_ffff);
    rdchk(A_VOTED, 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rdat, 32'h0);
    wr(A_SCAN, 32'h1);
    rdchk(A_SCAN, 32'(SCAN_MIN));
    wr(A_SCAN, 32'h4);
  endtask : t_reset

  // Majority and disagreement over a table of patterns
  task t_vote;
    logic [15:0] tb [5][3];
    logic [15:0] m, d;
    tb = '{'{16'h0001, 16'h0000, 16'h0000}, '{16'h8000, 16'h8000, 16'h0000},
           '{16'hffff, 16'h0f0f, 16'hf0f0}, '{16'h1234, 16'hffff, 16'h1234},
           '{16'h00ff, 16'h00ff, 16'h00ff}};
    for (int k = 0; k < 5; k++) begin
      set_brd(tb[k][0], tb[k][1], tb[k][2], 3'h0, 3'h7);
      m = (tb[k][0] & tb[k][1]) | (tb[k][0] & tb[k][2]) | (tb[k][1] & tb[k][2]);
      d = (tb[k][0] ^ tb[k][1]) | (tb[k][1] ^ tb[k][2]);
      chk_res(m, 3'h0, d);
    end
  endtask : t_vote

  // Faulty board, then a pulled board
  task t_fault;
    set_brd(16'h3c3c, 16'h3c3c, 16'h3c3c, 3'h2, 3'h7);
    chk_res(16'h3c3c, 3'h2, 16'h0);
    rdchk(A_FAULT, 32'h2);
    apb(A_ISTAT, 1'b0, 32'h0);
    chk(32'(rdat[EV_FAULT]), 32'h1);
    set_brd(16'h00ff, 16'h0f0f, 16'h5555, 3'h0, 3'h3);
    chk_res(16'h000f, 3'h4, 16'h0ff0);
  endtask : t_fault

  // Single board pass-through
  task t_simplex;
    wr(A_CTRL, 32'h3);
    set_brd(16'ha5c3, 16'hffff, 16'h0000, 3'h6, 3'h7);
    chk_res(16'ha5c3, 3'h0, 16'h0);
    set_brd(16'h5a3c, 16'hffff, 16'h0000, 3'h1, 3'h7);
    chk_res(16'h5a3c, 3'h1, 16'h0);
    wr(A_CTRL, 32'h1);
  endtask : t_simplex

  // Raise, mask and clear the discrepancy interrupt
  task t_irq;
    wr(A_ISTAT, 32'h7);
    wr(A_IMASK, 32'h1 << EV_DISC);
    set_brd(16'h0000, 16'h0010, 16'h0000, 3'h0, 3'h7);
    wait_scan(3);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq), 32'h1);
    apb(A_ISTAT, 1'b0, 32'h0);
    chk(rdat & 32'h5, 32'h5);
    wr(A_IMASK, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq), 32'h0);
    wr(A_IMASK, 32'h1 << EV_DISC);
    set_brd(16'h0000, 16'h0000, 16'h0000, 3'h0, 3'h7);
    wait_scan(3);
    wr(A_ISTAT, 32'h1 << EV_DISC);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq), 32'h0);
    apb(A_ISTAT, 1'b0, 32'h0);
    chk(32'(rdat[EV_DISC]), 32'h0);
  endtask : t_irq

  // Host location limits gate the scans
  task t_hloc;
    logic [15:0] hv [6];
    logic        hb [6];
    int          cnt;
    hv = '{16'h0801, 16'h0c0a, 16'h0901, 16'h010b, 16'h0d02, 16'h0002};
    hb = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    for (int k = 0; k < 6; k++) begin
      wr(A_HLOC, 32'(hv[k]));
      rdchk(A_HLOC, {15'h0, hb[k], hv[k]});
      cnt = 0;
      repeat (12) begin
        @(posedge pclk);
        #1;
        if (scan_strobe === 1'b1) cnt++;
      end
      chk(32'(cnt != 0), 32'(!hb[k]));
    end
    wr(A_HLOC, 32'h0101);
    // Scanning switched off: no strobes at all
    wr(A_CTRL, 32'h0);
    rdchk(A_CTRL, 32'h0);
    cnt = 0;
    repeat (12) begin
      @(posedge pclk);
      #1;
      if (scan_strobe === 1'b1) cnt++;
    end
    chk(32'(cnt), 32'h0);
    wr(A_CTRL, 32'h1);
  endtask : t_hloc

  // Main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    for (int i = 0; i < NBRD; i++) begin
      b_fit[i] = 1'b1;
      b_flt[i] = 1'b0;
      b_dat[i] = '0;
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_vote();
    t_fault();
    t_simplex();
    t_irq();
    t_hloc();
    conclude();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    conclude();
  end
endmodule : testbench
